// ### hdl/ifb_bank.sv
// Interrupt request flags, enables, edge select and global enable,
// reached over AXI4-Lite, with the pending request offered to the core.
// Assumes all inputs synchronous to CLOCK; the core pulses IRQ_ACK for one
// cycle when it takes the vector shown on IRQ_VECTOR.
//
// Behaviour
// R1 - Edge select 00 off, 01 rising, 10 falling, 11 both edges.
// R2 - Control 0 bit 5 is the touch key request flag.
// R3 - Control 0 bit 4 is the pin request flag, set by a selected edge.
// R4 - Control 0 bit 1 enables the pin interrupt.
// R5 - Control 0 bit 6 is the time base 0 request flag.
// R6 - Control 1 bit 7 flags periodic timer compare A match.
// R7 - Control 1 bit 6 flags periodic timer compare P match.
// R8 - Control 1 bit 5 flags compact timer compare A match.
// R9 - Control 1 bit 4 flags compact timer compare P match.
// R10 - Control 1 bit 3 enables periodic timer compare A interrupt.
// R11 - Control 1 bit 2 enables periodic timer compare P interrupt.
// R12 - Control 1 bit 1 enables compact timer compare A interrupt.
// R13 - Control 1 bit 0 enables compact timer compare P interrupt.
// R14 - Control 2 bit 7 is the UART request flag.
// R15 - Control 2 bit 6 is the data EEPROM request flag.
// R16 - Control 2 bit 2 enables the data EEPROM interrupt.
// R17 - Control 2 bit 5 is the I2C request flag.
// R18 - All bits reset to zero; unimplemented bits read zero.
// R19 - Global enable low blocks every interrupt.
// R20 - A flag interrupts only with its enable set; else it just stays.
// R21 - Servicing clears global enable; new flags still get recorded.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ifb_defines.svh"

module ifb_bank
    import ifb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RSTN,
    // Interrupt sources
    input  wire logic              EXT_PIN,
    input  wire ifb_events_t       EVENTS,
    // Core side
    input  wire logic              IRQ_ACK,
    output      logic              IRQ_REQ,
    output      logic [3:0]        IRQ_VECTOR,
    // AXI4-Lite write address and data
    input  wire logic              AWVALID,
    output      logic              AWREADY,
    input  wire logic [ADDR_W-1:0] AWADDR,
    input  wire logic              WVALID,
    output      logic              WREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    // AXI4-Lite write response
    output      logic              BVALID,
    input  wire logic              BREADY,
    output      logic [1:0]        BRESP,
    // AXI4-Lite read
    input  wire logic              ARVALID,
    output      logic              ARREADY,
    input  wire logic [ADDR_W-1:0] ARADDR,
    output      logic              RVALID,
    input  wire logic              RREADY,
    output      logic [31:0]       RDATA,
    output      logic [1:0]        RRESP
);

    // Where each source keeps its flag and enable bit
    localparam logic [2:0] FREG [`IFB_NUM_SRC] = '{
        `IFB_REG_C0, `IFB_REG_C0, `IFB_REG_C0,
        `IFB_REG_C1, `IFB_REG_C1, `IFB_REG_C1, `IFB_REG_C1,
        `IFB_REG_C2, `IFB_REG_C2, `IFB_REG_C2, `IFB_REG_C2,
        `IFB_REG_C3};
    localparam logic [2:0] FBIT [`IFB_NUM_SRC] = '{
        `IFB_BIT_F4, `IFB_BIT_F5, `IFB_BIT_F6,
        `IFB_BIT_F4, `IFB_BIT_F5, `IFB_BIT_F6, `IFB_BIT_F7,
        `IFB_BIT_F4, `IFB_BIT_F5, `IFB_BIT_F6, `IFB_BIT_F7,
        `IFB_BIT_F4};
    localparam logic [2:0] EBIT [`IFB_NUM_SRC] = '{
        `IFB_BIT_E1, `IFB_BIT_E2, `IFB_BIT_E3,
        `IFB_BIT_E0, `IFB_BIT_E1, `IFB_BIT_E2, `IFB_BIT_E3,
        `IFB_BIT_E0, `IFB_BIT_E1, `IFB_BIT_E2, `IFB_BIT_E3,
        `IFB_BIT_E0};

    ifb_state_t   s_q;
    ifb_state_t   s_d;
    ifb_src_vec_t ev;
    logic         pin_rise;
    logic         pin_fall;
    logic         do_wr;
    logic         wr_en;
    logic         ack;
    logic [2:0]   ar_idx;
    logic         ar_ok;
    ifb_src_vec_t pend;

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        addr_ok = (a[ADDR_W-1:`IFB_IDX_MSB+1] == '0)
            && (a[`IFB_ADDR_LSB-1:0] == '0)
            && (a[`IFB_IDX_MSB:`IFB_ADDR_LSB] < `IFB_NUM_REGS);
    endfunction : addr_ok

    // Read image of one register; absent bits stay zero
    function automatic logic [7:0] image(input ifb_state_t s,
                                         input logic [2:0] idx);
        logic [7:0] r;
        r = 8'h00;
        if (idx == `IFB_REG_EDGE) begin
            r[`IFB_BIT_SEL_LO] = s.edge_sel[0];
            r[`IFB_BIT_SEL_HI] = s.edge_sel[1];
        end
        if (idx == `IFB_REG_C0) begin
            r[`IFB_BIT_EMI] = s.global_irq_enable;
        end
        for (int i = 0; i < `IFB_NUM_SRC; i++) begin
            if (idx == FREG[i]) begin
                r[FBIT[i]] = s.flag[i];
                r[EBIT[i]] = s.en[i];
            end
        end
        image = r; // [R18] [R2] [R14] [R15] [R17]
    endfunction : image

    always_comb begin
        s_d = s_q;
        // Selected pin edges
        pin_rise = EXT_PIN && !s_q.pin_prev;
        pin_fall = !EXT_PIN && s_q.pin_prev;
        ev = {EVENTS, 1'b0};
        ev[`IFB_SRC_EXT] = (s_q.edge_sel[0] && pin_rise)
            || (s_q.edge_sel[1] && pin_fall); // [R1] [R3]
        s_d.pin_prev = EXT_PIN;

        // Write channel capture, in either order
        if (AWVALID && s_q.awready) begin
            s_d.aw_held = 1'b1;
            s_d.aw_idx  = AWADDR[`IFB_IDX_MSB:`IFB_ADDR_LSB];
            s_d.aw_ok   = addr_ok(AWADDR);
        end
        if (WVALID && s_q.wready) begin
            s_d.w_held = 1'b1;
            s_d.wdata  = WDATA[7:0];
            s_d.wstrb0 = WSTRB[0];
        end
        if (BVALID && BREADY) begin
            s_d.bvalid = 1'b0;
        end
        do_wr = s_q.aw_held && s_q.w_held && !s_q.bvalid;
        wr_en = do_wr && s_q.aw_ok && s_q.wstrb0;
        if (do_wr) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = s_q.aw_ok ? `IFB_RESP_OKAY : `IFB_RESP_SLVERR;
        end

        // Core takes the vector on show
        ack = IRQ_ACK && s_q.irq_req;

        if (wr_en && s_q.aw_idx == `IFB_REG_EDGE) begin
            s_d.edge_sel[0] = s_q.wdata[`IFB_BIT_SEL_LO]; // [R1]
            s_d.edge_sel[1] = s_q.wdata[`IFB_BIT_SEL_HI];
        end
        if (wr_en && s_q.aw_idx == `IFB_REG_C0) begin
            s_d.global_irq_enable = s_q.wdata[`IFB_BIT_EMI];
        end
        if (ack) begin
            s_d.global_irq_enable = 1'b0; // [R21]
        end

        // Flags: hardware set wins over software or service clear
        for (int i = 0; i < `IFB_NUM_SRC; i++) begin
            if (wr_en && s_q.aw_idx == FREG[i]) begin
                s_d.flag[i] = s_q.wdata[FBIT[i]];
                // [R4] [R10] [R11] [R12] [R13] [R16]
                s_d.en[i]   = s_q.wdata[EBIT[i]];
            end
            if (ack && s_q.irq_vec == 4'(i)) begin
                s_d.flag[i] = 1'b0;
            end
            // [R2] [R3] [R5] [R6] [R7] [R8] [R9] [R14] [R15] [R17] [R21]
            s_d.flag[i] = s_d.flag[i] || ev[i];
        end

        // Read channel
        ar_idx = ARADDR[`IFB_IDX_MSB:`IFB_ADDR_LSB];
        ar_ok  = addr_ok(ARADDR);
        if (RVALID && RREADY) begin
            s_d.rvalid = 1'b0;
        end
        if (ARVALID && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = ar_ok ? image(s_q, ar_idx) : 8'h00;
            s_d.rresp  = ar_ok ? `IFB_RESP_OKAY : `IFB_RESP_SLVERR;
        end

        // Highest priority enabled request
        pend = s_d.flag & s_d.en; // [R20]
        s_d.irq_vec = s_q.irq_vec;
        for (int i = `IFB_NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                s_d.irq_vec = 4'(i);
            end
        end
        s_d.irq_req = s_d.global_irq_enable && (pend != '0); // [R19] [R20]

        s_d.awready = !s_d.aw_held && !s_d.bvalid;
        s_d.wready  = !s_d.w_held && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            s_q <= '0; // [R18]
        end else begin
            s_q <= s_d;
        end
    end

    assign IRQ_REQ    = s_q.irq_req;
    assign IRQ_VECTOR = s_q.irq_vec;
    assign AWREADY    = s_q.awready;
    assign WREADY     = s_q.wready;
    assign BVALID     = s_q.bvalid;
    assign BRESP      = s_q.bresp;
    assign ARREADY    = s_q.arready;
    assign RVALID     = s_q.rvalid;
    assign RDATA      = {24'h000000, s_q.rdata};
    assign RRESP      = s_q.rresp;

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    sequence s_taken;
        IRQ_ACK && IRQ_REQ;
    endsequence

    sequence s_no_write;
        !(s_q.aw_held && s_q.w_held && !s_q.bvalid);
    endsequence

    chk_global_gate: assert property ( // [R19]
        !s_q.global_irq_enable |-> !IRQ_REQ)
        else $error("request shown with global enable low");

    chk_enable_gate: assert property ( // [R20]
        IRQ_REQ |-> (s_q.flag[IRQ_VECTOR] && s_q.en[IRQ_VECTOR]))
        else $error("request shown for a masked or idle source");

    chk_service_emi: assert property ( // [R21]
        s_taken ##1 s_no_write |=> !s_q.global_irq_enable && !IRQ_REQ)
        else $error("global enable survived servicing");

    chk_service_rec: assert property ( // [R21]
        s_taken ##0 EVENTS.uart |=> s_q.flag[`IFB_SRC_UART])
        else $error("event lost during servicing");

    chk_rise_edge: assert property ( // [R1]
        s_q.edge_sel == 2'h1 && $rose(EXT_PIN)
        |=> s_q.flag[`IFB_SRC_EXT])
        else $error("rising edge not recorded");

    chk_fall_edge: assert property ( // [R3]
        s_q.edge_sel == 2'h2 && $fell(EXT_PIN)
        |=> s_q.flag[`IFB_SRC_EXT])
        else $error("falling edge not recorded");

    chk_edge_off: assert property ( // [R1]
        s_q.edge_sel == 2'h0 && !s_q.flag[`IFB_SRC_EXT] ##0 s_no_write
        |=> !s_q.flag[`IFB_SRC_EXT])
        else $error("pin flag set with edges disabled");

    chk_timer_flag: assert property ( // [R6]
        EVENTS.periodic_a |=> s_q.flag[`IFB_SRC_PTMA] [*1])
        else $error("compare event not recorded");

    chk_touch_flag: assert property ( // [R2]
        EVENTS.touch |=> s_q.flag[`IFB_SRC_TKM])
        else $error("touch request not recorded");

    chk_dual_edge: assert property ( // [R1]
        s_q.edge_sel == 2'h3 && $changed(EXT_PIN)
        |=> s_q.flag[`IFB_SRC_EXT])
        else $error("pin edge lost in dual edge mode");

    chk_read_zero: assert property ( // [R18]
        RVALID |-> RDATA[31:8] == 24'h000000
            && (RRESP == `IFB_RESP_OKAY || RDATA[7:0] == 8'h00))
        else $error("upper or refused read bits not zero");

    chk_read_hold: assert property ( // [R18]
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read answer dropped before taken");

endmodule : ifb_bank

// ### shared/ifb_defines.svh
// Register indices, field positions and bus codes of the interrupt bank.
// Assumes nothing; included by the package users by bare name.
`ifndef IFB_DEFINES_SVH
`define IFB_DEFINES_SVH

`define IFB_NUM_SRC     12
`define IFB_NUM_REGS    3'h5
`define IFB_ADDR_LSB    2
`define IFB_IDX_MSB     4

// Register indices; byte address is four times the index
`define IFB_REG_EDGE    3'h0
`define IFB_REG_C0      3'h1
`define IFB_REG_C1      3'h2
`define IFB_REG_C2      3'h3
`define IFB_REG_C3      3'h4

// Field positions inside the 8-bit registers
`define IFB_BIT_SEL_LO  3'h0
`define IFB_BIT_SEL_HI  3'h1
`define IFB_BIT_EMI     3'h0
`define IFB_BIT_E0      3'h0
`define IFB_BIT_E1      3'h1
`define IFB_BIT_E2      3'h2
`define IFB_BIT_E3      3'h3
`define IFB_BIT_F4      3'h4
`define IFB_BIT_F5      3'h5
`define IFB_BIT_F6      3'h6
`define IFB_BIT_F7      3'h7

// Source numbers in priority order, 0 is highest
`define IFB_SRC_EXT     4'h0
`define IFB_SRC_TKM     4'h1
`define IFB_SRC_TB0     4'h2
`define IFB_SRC_CTMP    4'h3
`define IFB_SRC_CTMA    4'h4
`define IFB_SRC_PTMP    4'h5
`define IFB_SRC_PTMA    4'h6
`define IFB_SRC_TB1     4'h7
`define IFB_SRC_IIC     4'h8
`define IFB_SRC_DE      4'h9
`define IFB_SRC_UART    4'ha
`define IFB_SRC_LVD     4'hb

`define IFB_RESP_OKAY   2'h0
`define IFB_RESP_SLVERR 2'h2

`endif

// ### shared/ifb_pkg.sv
// Types of the interrupt flag and enable bank.
// Assumes ifb_defines.svh for the widths it uses.
`include "ifb_defines.svh"

package ifb_pkg;

    typedef logic [`IFB_NUM_SRC-1:0] ifb_src_vec_t;

    // One-cycle request pulses from the peripherals
    typedef struct packed {
        logic lvd;
        logic uart;
        logic eeprom;
        logic i2c;
        logic time_base1;
        logic periodic_a;
        logic periodic_p;
        logic compact_a;
        logic compact_p;
        logic time_base0;
        logic touch;
    } ifb_events_t;

    typedef struct packed {
        logic [1:0]   edge_sel;
        ifb_src_vec_t flag;
        ifb_src_vec_t en;
        logic         global_irq_enable;
        logic         pin_prev;
        logic         aw_held;
        logic [2:0]   aw_idx;
        logic         aw_ok;
        logic         w_held;
        logic [7:0]   wdata;
        logic         wstrb0;
        logic         awready;
        logic         wready;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         arready;
        logic         rvalid;
        logic [7:0]   rdata;
        logic [1:0]   rresp;
        logic         irq_req;
        logic [3:0]   irq_vec;
    } ifb_state_t;

endpackage : ifb_pkg

// ### verif/ifb_bank_tb.sv
// Self-checking bench of the interrupt flag and enable bank.
// Assumes ifb_pkg and ifb_defines.svh are compiled ahead of it.
`timescale 1ns/1ps
`include "ifb_defines.svh"

module ifb_bank_tb
    import ifb_pkg::*;
;
    logic        clock, rstn, ext_pin, irq_ack, irq_req;
    ifb_events_t events;
    logic [3:0]  irq_vector, wstrb, wstrb_use;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp;
    int          err_total, n_checks, seed;

    // Readable bits of each register, and where each event lands
    localparam logic [7:0] MASK [5] = '{8'h03, 8'h7f, 8'hff, 8'hff, 8'h11};
    localparam int EVR [11] = '{1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 4};
    localparam int EVB [11] = '{5, 6, 4, 5, 6, 7, 4, 5, 6, 7, 4};

    ifb_bank ifb_bank_inst (
        .CLOCK(clock), .RSTN(rstn), .EXT_PIN(ext_pin), .EVENTS(events),
        .IRQ_ACK(irq_ack), .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vector),
        .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
        .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
        .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
        .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
        .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    function automatic logic [7:0] adr(input logic [2:0] i);
        return {3'h0, i, 2'b00};
    endfunction : adr

    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic tmo(input int n);
        if (n >= 50) begin
            err_total++;
            $display("[ERR] bus_wait exp answer got timeout");
            print_verdict();
        end
    endtask : tmo

    task automatic step(input int k);
        repeat (k) @(posedge clock);
    endtask : step

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          input logic [1:0] er);
        int n;
        bit aw, w;
        aw = 0;
        w = 0;
        n = 0;
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= v;
        wstrb   <= wstrb_use;
        bready  <= 1'b1;
        while (!(aw && w) && n < 50) begin
            @(posedge clock);
            n++;
            if (!aw && awready) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid && n < 50) begin
            @(posedge clock);
            n++;
        end
        // Ready stays up so back-to-back calls never drive it twice at once
        tmo(n);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (!arready && n < 50);
        arvalid <= 1'b0;
        while (!rvalid && n < 50) begin
            @(posedge clock);
            n++;
        end
        tmo(n);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        chk("rdata", ed, rdata);
    endtask : axi_rd

    initial begin
        seed = 89;
        err_total = 0;
        n_checks = 0;
        {rstn, ext_pin, irq_ack, awvalid, wvalid, bready} = '0;
        {arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
        events = '0;
        wstrb_use = 4'hf;
        step(3);
        rstn <= 1'b1;
        step(1);
        for (int i = 0; i < 5; i++)
            axi_rd(adr(i), 32'h0, `IFB_RESP_OKAY);
        axi_rd(8'h14, 32'h0, `IFB_RESP_SLVERR);
        axi_rd(8'h05, 32'h0, `IFB_RESP_SLVERR);
        axi_wr(8'h14, 32'hff, `IFB_RESP_SLVERR);
        // Random patterns read back through the implemented bits only
        for (int i = 0; i < 5; i++)
            for (int k = 0; k < 3; k++) begin
                d = $random(seed);
                axi_wr(adr(i), d, `IFB_RESP_OKAY);
                axi_rd(adr(i), {24'h0, d[7:0] & MASK[i]},
                       `IFB_RESP_OKAY);
            end
        for (int i = 0; i < 5; i++)
            axi_wr(adr(i), 32'h0, `IFB_RESP_OKAY);
        // Each event pulse sets its own flag and nothing else
        for (int k = 0; k < 11; k++) begin
            events <= ifb_events_t'(11'h1 << k);
            @(posedge clock);
            events <= '0;
            axi_rd(adr(EVR[k]), 32'h1 << EVB[k],
                   `IFB_RESP_OKAY);
            axi_wr(adr(EVR[k]), 32'h0, `IFB_RESP_OKAY);
        end
        for (int s = 0; s < 4; s++) begin
            axi_wr(adr(`IFB_REG_EDGE), s, `IFB_RESP_OKAY);
            axi_wr(adr(`IFB_REG_C0), 32'h0, `IFB_RESP_OKAY);
            ext_pin <= 1'b1;
            step(2);
            axi_rd(adr(`IFB_REG_C0), {27'h0, s[0], 4'h0},
                   `IFB_RESP_OKAY);
            axi_wr(adr(`IFB_REG_C0), 32'h0, `IFB_RESP_OKAY);
            ext_pin <= 1'b0;
            step(2);
            axi_rd(adr(`IFB_REG_C0), {27'h0, s[1], 4'h0},
                   `IFB_RESP_OKAY);
        end
        axi_wr(adr(`IFB_REG_C2), 32'h04, `IFB_RESP_OKAY);
        events <= ifb_events_t'(11'h100);
        @(posedge clock);
        events <= '0;
        step(2);
        chk("irq_req", 32'h0, irq_req);
        axi_wr(adr(`IFB_REG_C0), 32'h01, `IFB_RESP_OKAY);
        step(1);
        chk("irq_req", 32'h1, irq_req);
        chk("irq_vector", 32'h9, irq_vector);
        axi_wr(adr(`IFB_REG_C2), 32'h40, `IFB_RESP_OKAY);
        step(1);
        chk("irq_req", 32'h0, irq_req);
        axi_wr(adr(`IFB_REG_C2), 32'h44, `IFB_RESP_OKAY);
        step(1);
        chk("irq_req", 32'h1, irq_req);
        // Service while a new request arrives in the same cycle
        irq_ack <= 1'b1;
        events  <= ifb_events_t'(11'h200);
        @(posedge clock);
        irq_ack <= 1'b0;
        events  <= '0;
        step(1);
        chk("irq_req", 32'h0, irq_req);
        axi_rd(adr(`IFB_REG_C0), 32'h0, `IFB_RESP_OKAY);
        axi_rd(adr(`IFB_REG_C2), 32'h84, `IFB_RESP_OKAY);
        axi_wr(adr(`IFB_REG_EDGE), 32'h1, `IFB_RESP_OKAY);
        axi_wr(adr(`IFB_REG_C0), 32'h03, `IFB_RESP_OKAY);
        ext_pin <= 1'b1;
        step(2);
        chk("irq_req", 32'h1, irq_req);
        chk("irq_vector", 32'h0, irq_vector);
        axi_wr(adr(`IFB_REG_C0), 32'h11, `IFB_RESP_OKAY);
        step(1);
        chk("irq_req", 32'h0, irq_req);
        // A stray acknowledge with nothing shown changes nothing
        irq_ack <= 1'b1;
        @(posedge clock);
        irq_ack <= 1'b0;
        axi_rd(adr(`IFB_REG_C0), 32'h11, `IFB_RESP_OKAY);
        // Low byte strobe off: the write is answered but dropped
        wstrb_use = 4'he;
        axi_wr(adr(`IFB_REG_C1), 32'hff, `IFB_RESP_OKAY);
        wstrb_use = 4'hf;
        axi_rd(adr(`IFB_REG_C1), 32'h0, `IFB_RESP_OKAY);
        // Reset in mid-run brings every register back to zero
        rstn <= 1'b0;
        step(2);
        rstn <= 1'b1;
        step(1);
        chk("irq_req", 32'h0, irq_req);
        for (int i = 0; i < 5; i++)
            axi_rd(adr(i), 32'h0, `IFB_RESP_OKAY);
        print_verdict();
    end

endmodule : ifb_bank_tb
